/* hw/opc_blink.sv */
// Blink pattern generator: period and on-time counted in tick pulses.
// Assumes tick is a one-cycle enable on clk.
`timescale 1ns/1ps
module opc_blink #(
    parameter int unsigned PERIOD = 2000,
    parameter int unsigned ON_CNT = 1500
) (
    input  wire logic clk,      // System clock
    input  wire logic sys_rst,  // Sync reset, high
    input  wire logic tick,     // Time base enable
    output logic      lampOn    // Pattern level
);
    // Elaboration check: the pattern needs both a lit and a dark stretch
    if (PERIOD < 2 || ON_CNT == 0 || ON_CNT >= PERIOD) begin : g_bad_cfg
        $error("opc_blink: bad period or on count");
    end

    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (tick) begin
            nxt_cnt = (cnt_ff == PERIOD - 1) ? 32'h0 : cnt_ff + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_ff <= 32'h0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign lampOn = (cnt_ff < ON_CNT);
endmodule : opc_blink

/* hw/opc_permit_ctrl.sv */
// Permit decision and lamp logic of a loading-rack overfill controller.
// Assumes connector sense pins are asynchronous; bypass key lookup done outside.
`timescale 1ns/1ps
module opc_permit_ctrl #(
    parameter int unsigned TICK_DIV   = opc_pkg::TICK_CYC,
    parameter int unsigned SLOW_MS    = opc_pkg::SLOW_BLINK_MS,
    parameter int unsigned FAST_MS    = opc_pkg::FAST_BLINK_MS,
    parameter int unsigned OPTIC_MS   = opc_pkg::OPTIC_DET_MS,
    parameter int unsigned WARM_MS    = opc_pkg::WARMUP_MS,
    parameter int unsigned CLR_MS     = opc_pkg::CLEAR_MS
) (
    input  wire logic                 clk,             // 100 MHz clock
    input  wire logic                 sys_rst,         // Sync reset, high
    input  wire logic                 vehiclePresent,  // Plug sense pin
    input  wire logic                 opticReturn,     // Five-wire echo seen
    input  wire logic [7:0]           sensorWet,       // Per-compartment wet pins
    input  wire logic                 groundOk,        // Ground proven pin
    input  wire logic                 groundDetectJumper, // Jumper fitted
    input  wire logic                 vehicleIdOk,     // Id module authorised
    input  wire logic                 bypassKeyValid,  // Key on authorized_vehicle_list
    input  wire logic                 deadmanClosed,   // Deadman switch closed
    input  wire logic                 deadmanNearEnd,  // Close time nearly used
    input  wire logic                 deadmanExpired,  // Close time used up
    output logic                      permit,          // Main relay drive
    output logic                      redLamp,         // Non-permit lamp
    output logic                      greenLamp,       // Permit lamp
    output logic [7:0]                compLamp,        // Compartment lamps
    output logic                      fiveWire         // Optic sensors classified
);
    if (TICK_DIV < 2 || SLOW_MS < 4 || FAST_MS < 2
        || OPTIC_MS == 0 || WARM_MS == 0 || CLR_MS < 2) begin : g_bad_cfg
        $error("opc_permit_ctrl: bad parameter");
    end

    // Two-stage synchronisers for all pins
    localparam int unsigned SW = 17;
    logic [SW-1:0] meta_ff, sync_ff;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= {vehiclePresent, opticReturn, sensorWet, groundOk, groundDetectJumper,
                        vehicleIdOk, bypassKeyValid, deadmanClosed, deadmanNearEnd, deadmanExpired};
            sync_ff <= meta_ff;
        end
    end
    logic       sPresent, sOptic, sGround, sJumper, sIdOk, sKey, sDmClosed, sDmNear, sDmExp;
    logic [7:0] sWet;
    assign {sPresent, sOptic, sWet, sGround, sJumper, sIdOk, sKey, sDmClosed, sDmNear, sDmExp} = sync_ff;

    // Millisecond tick divider
    logic [31:0] div_ff, nxt_div;
    logic        tick;
    always_comb begin
        nxt_div = (div_ff == TICK_DIV - 1) ? 32'h0 : div_ff + 32'h1;
    end
    always_ff @(posedge clk) begin
        if (sys_rst) div_ff <= 32'h0;
        else         div_ff <= nxt_div;
    end
    assign tick = (div_ff == TICK_DIV - 1);

    logic slowOn, fastOn, flashOn;
    opc_blink #(.PERIOD(SLOW_MS), .ON_CNT((SLOW_MS * 3) / 4)) u_slow (
        .clk(clk), .sys_rst(sys_rst), .tick(tick), .lampOn(slowOn));
    opc_blink #(.PERIOD(FAST_MS), .ON_CNT(FAST_MS / 2)) u_fast (
        .clk(clk), .sys_rst(sys_rst), .tick(tick), .lampOn(fastOn));
    opc_blink #(.PERIOD(2 * opc_pkg::FLASH_HALF_MS), .ON_CNT(opc_pkg::FLASH_HALF_MS)) u_flash (
        .clk(clk), .sys_rst(sys_rst), .tick(tick), .lampOn(flashOn));

    // Main sequencer
    opc_pkg::opc_state_t  state_ff, nxt_state;
    opc_pkg::opc_sensor_t sns_ff, nxt_sns;
    logic [31:0]          tmr_ff, nxt_tmr;
    opc_pkg::opc_fault_t  flt_ff, nxt_flt;
    logic                 byp_ff, nxt_byp;

    logic groundBad;
    assign groundBad = sJumper & ~sGround;

    always_comb begin
        nxt_state = state_ff;
        nxt_sns   = sns_ff;
        nxt_tmr   = tick ? tmr_ff + 32'h1 : tmr_ff;
        nxt_flt   = flt_ff;
        nxt_byp   = byp_ff;
        case (state_ff)
            opc_pkg::OPC_IDLE: begin
                nxt_tmr = 32'h0;
                nxt_sns = opc_pkg::OPC_SNS_NONE;
                nxt_byp = 1'b0;
                if (sPresent) begin
                    nxt_state = opc_pkg::OPC_DETECT;
                end
            end
            opc_pkg::OPC_DETECT: begin
                if (!sPresent) begin
                    nxt_state = opc_pkg::OPC_FLASH;
                    nxt_tmr   = 32'h0;
                end else if (sOptic) begin
                    nxt_sns   = opc_pkg::OPC_SNS_FIVE;
                    nxt_state = opc_pkg::OPC_MONITOR;
                end else if (tmr_ff >= OPTIC_MS) begin
                    nxt_sns   = opc_pkg::OPC_SNS_TWO;
                    nxt_state = opc_pkg::OPC_WARM;
                    nxt_tmr   = 32'h0;
                end
                // Faults latched at connection time
                nxt_flt = '{idFault: ~sIdOk, groundFault: groundBad, sensorFault: 1'b0};
            end
            opc_pkg::OPC_WARM: begin
                // Wet during warm-up is normal; only a timeout marks a sensor fault
                if (!sPresent) begin
                    nxt_state = opc_pkg::OPC_FLASH;
                    nxt_tmr   = 32'h0;
                end else if (sWet == opc_pkg::COMP_NONE) begin
                    nxt_state = opc_pkg::OPC_MONITOR;
                end else if (tmr_ff >= WARM_MS) begin
                    nxt_flt.sensorFault = 1'b1;
                    nxt_state           = opc_pkg::OPC_MONITOR;
                end
            end
            opc_pkg::OPC_MONITOR: begin
                if (!sPresent) begin
                    nxt_state = opc_pkg::OPC_FLASH;
                    nxt_tmr   = 32'h0;
                end else if (sKey) begin
                    nxt_byp = 1'b1;
                end
            end
            opc_pkg::OPC_FLASH: begin
                if (tmr_ff >= CLR_MS) begin
                    nxt_state = opc_pkg::OPC_IDLE;
                end
            end
            default: nxt_state = opc_pkg::OPC_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= opc_pkg::OPC_IDLE;
            sns_ff   <= opc_pkg::OPC_SNS_NONE;
            tmr_ff   <= 32'h0;
            flt_ff   <= '0;
            byp_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            sns_ff   <= nxt_sns;
            tmr_ff   <= nxt_tmr;
            flt_ff   <= nxt_flt;
            byp_ff   <= nxt_byp;
        end
    end

    // Permit decision and lamps
    logic anyFault, liveWet, allowed, bypGreen;
    logic nxt_permit, nxt_red, nxt_green, nxt_five;
    logic [7:0] nxt_comp;
    logic permit_ff, red_ff, green_ff, five_ff;
    logic [7:0] comp_ff;

    // Five-wire wetness shows on lamp 0 via loss of the optic echo
    assign liveWet  = (sns_ff == opc_pkg::OPC_SNS_FIVE) ? ~sOptic : |sWet;
    assign anyFault = flt_ff.idFault | flt_ff.groundFault | flt_ff.sensorFault | liveWet;
    // Bypass key covers latched faults only; deadman is never overridden
    assign allowed  = (state_ff == opc_pkg::OPC_MONITOR) & sPresent
                      & (~anyFault | (byp_ff & ~liveWet))
                      & sDmClosed & ~sDmExp;
    assign bypGreen = byp_ff & (flt_ff.idFault | flt_ff.groundFault);

    always_comb begin
        nxt_permit = allowed;
        nxt_red    = ~allowed;
        nxt_five   = (sns_ff == opc_pkg::OPC_SNS_FIVE);
        nxt_comp   = opc_pkg::COMP_NONE;
        if (!allowed) begin
            nxt_green = 1'b0;
        end else if (sDmNear) begin
            nxt_green = fastOn;
        end else if (bypGreen) begin
            nxt_green = slowOn;
        end else begin
            nxt_green = 1'b1;
        end
        if (state_ff == opc_pkg::OPC_FLASH) begin
            nxt_comp = flashOn ? opc_pkg::COMP_ALL : opc_pkg::COMP_NONE;
        end else if (state_ff == opc_pkg::OPC_WARM || state_ff == opc_pkg::OPC_MONITOR) begin
            nxt_comp = (sns_ff == opc_pkg::OPC_SNS_FIVE) ? {7'h00, liveWet} : sWet;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            permit_ff <= 1'b0;
            red_ff    <= 1'b1;
            green_ff  <= 1'b0;
            five_ff   <= 1'b0;
            comp_ff   <= opc_pkg::COMP_NONE;
        end else begin
            permit_ff <= nxt_permit;
            red_ff    <= nxt_red;
            green_ff  <= nxt_green;
            five_ff   <= nxt_five;
            comp_ff   <= nxt_comp;
        end
    end

    assign permit    = permit_ff;
    assign redLamp   = red_ff;
    assign greenLamp = green_ff;
    assign compLamp  = comp_ff;
    assign fiveWire  = five_ff;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence disconnectSeen;
        $fell(sPresent);
    endsequence

    chk_disconnect_drop: assert property (disconnectSeen |=> !permit)
        else $error("permit held after disconnect");
    chk_deadman_open: assert property (!sDmClosed |=> !permit)
        else $error("permit with deadman open");
    chk_deadman_expiry: assert property (sDmExp |=> !permit)
        else $error("permit after deadman expiry");
    chk_wet_drop: assert property ((state_ff == opc_pkg::OPC_MONITOR && |sWet && !byp_ff
                                   && sns_ff == opc_pkg::OPC_SNS_TWO) |=> !permit)
        else $error("permit while wet");
    chk_red_green: assert property (redLamp |-> !greenLamp)
        else $error("red and green both lit");
    chk_permit_state: assert property (permit |-> $past(state_ff) == opc_pkg::OPC_MONITOR)
        else $error("permit outside monitor");
    chk_optic_time: assert property ((state_ff == opc_pkg::OPC_DETECT && tmr_ff >= OPTIC_MS)
                                    |=> state_ff != opc_pkg::OPC_DETECT)
        else $error("sensor detection too slow");
    chk_flash_all: assert property ((state_ff == opc_pkg::OPC_FLASH && flashOn)
                                   |=> compLamp == opc_pkg::COMP_ALL)
        else $error("disconnect flash missing");
    chk_jumper_off: assert property ((state_ff == opc_pkg::OPC_DETECT && !sJumper)
                                    |=> !flt_ff.groundFault)
        else $error("ground fault with detection off");

    // Sensor classification and warm-up
    sequence opticSeen;
        state_ff == opc_pkg::OPC_DETECT && sPresent && sOptic;
    endsequence

    sequence detectTimeout;
        state_ff == opc_pkg::OPC_DETECT && sPresent && !sOptic && tmr_ff >= OPTIC_MS;
    endsequence

    chk_five_class: assert property (opticSeen |=>
                                    (state_ff == opc_pkg::OPC_MONITOR && sns_ff == opc_pkg::OPC_SNS_FIVE))
        else $error("five-wire sensors not classified");
    chk_two_class: assert property (detectTimeout |=>
                                   (state_ff == opc_pkg::OPC_WARM && sns_ff == opc_pkg::OPC_SNS_TWO))
        else $error("two-wire sensors not classified");
    chk_warm_normal: assert property ((state_ff == opc_pkg::OPC_WARM && tmr_ff < WARM_MS)
                                     |=> !flt_ff.sensorFault)
        else $error("warm-up flagged as fault");
    chk_warm_timeout: assert property ((state_ff == opc_pkg::OPC_WARM && sWet != opc_pkg::COMP_NONE
                                       && sPresent && tmr_ff >= WARM_MS) |=> flt_ff.sensorFault)
        else $error("warm-up timeout not flagged");

    // Faults, bypass and permit
    sequence dryTwoWire;
        state_ff == opc_pkg::OPC_MONITOR && sns_ff == opc_pkg::OPC_SNS_TWO && sWet == opc_pkg::COMP_NONE;
    endsequence

    chk_key_refused: assert property ((!byp_ff && !(state_ff == opc_pkg::OPC_MONITOR && sKey))
                                     |=> !byp_ff)
        else $error("bypass taken without key");
    chk_red_fault: assert property ((state_ff == opc_pkg::OPC_MONITOR && !byp_ff && flt_ff != 3'h0)
                                   |=> redLamp)
        else $error("fault without red lamp");
    chk_dry_permit: assert property ((dryTwoWire ##0 (flt_ff == 3'h0 && sPresent && sDmClosed && !sDmExp))
                                    |=> permit)
        else $error("dry sensors without permit");
    chk_five_wet: assert property ((state_ff == opc_pkg::OPC_MONITOR && sns_ff == opc_pkg::OPC_SNS_FIVE
                                  && !sOptic) |=> (!permit && compLamp[0]))
        else $error("lost echo not shown");
    chk_flash_entry: assert property ((state_ff == opc_pkg::OPC_MONITOR && !sPresent)
                                     |=> state_ff == opc_pkg::OPC_FLASH)
        else $error("disconnect not flashed");

    // Green lamp patterns
    chk_steady_green: assert property ((allowed && !sDmNear && !bypGreen) |=> greenLamp)
        else $error("green not steady");
    chk_slow_dark: assert property ((allowed && !sDmNear && bypGreen && !slowOn) |=> !greenLamp)
        else $error("bypass blink missing");
    chk_fast_dark: assert property ((allowed && sDmNear && !fastOn) |=> !greenLamp)
        else $error("deadman blink missing");
endmodule : opc_permit_ctrl

/* shared/opc_pkg.sv */
// Shared constants and carrier types of the overfill permit controller.
// Assumes a 100 MHz clock; long times are counted by a 1 ms tick.
package opc_pkg;
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned TICK_NS         = 1_000_000;
    localparam int unsigned CLK_NS          = 10;
    localparam int unsigned TICK_CYC        = TICK_NS / CLK_NS;
    localparam int unsigned OPTIC_DET_MS    = 1000;
    localparam int unsigned WARMUP_S        = 75;
    localparam int unsigned WARMUP_MS       = WARMUP_S * 1000;
    localparam int unsigned CLEAR_MS        = 3000;
    localparam int unsigned FLASH_HALF_MS   = 250;
    localparam int unsigned SLOW_BLINK_MS   = 2000;
    localparam int unsigned FAST_BLINK_MS   = 500;
    localparam int unsigned NUM_COMP        = 8;
    localparam logic [7:0]  COMP_ALL        = 8'hff;
    localparam logic [7:0]  COMP_NONE       = 8'h00;

    typedef enum logic [2:0] {
        OPC_IDLE    = 3'b000,
        OPC_DETECT  = 3'b001,
        OPC_WARM    = 3'b010,
        OPC_MONITOR = 3'b011,
        OPC_FLASH   = 3'b100
    } opc_state_t;

    typedef enum logic [1:0] {
        OPC_SNS_NONE  = 2'b00,
        OPC_SNS_TWO   = 2'b01,
        OPC_SNS_FIVE  = 2'b10
    } opc_sensor_t;

    // Latched fault flags that travel together
    typedef struct packed {
        logic idFault;
        logic groundFault;
        logic sensorFault;
    } opc_fault_t;

    typedef struct packed {
        logic redLamp;
        logic greenLamp;
        logic [7:0] compLamp;
    } opc_lamp_t;
endpackage : opc_pkg

/* testbench/opc_vehicle_model.sv */
// Behavioural vehicle behind the rack plug: sensors, ground bond, id module.
// Assumes the bench moves its commands just after a rising clk edge.
`timescale 1ns/1ps
module opc_vehicle_model (
    input  wire logic        clk,            // System clock
    input  wire logic        plugged,        // Plug fitted to vehicle
    input  wire logic        optic,          // Five-wire sensors fitted
    input  wire logic [7:0]  wetCmd,         // Compartments made wet
    input  wire logic [15:0] warmCyc,        // Thermistor warm-up span
    input  wire logic        groundGood,     // Chassis bond intact
    input  wire logic        idGood,         // Id module authorised
    output logic             vehiclePresent, // Plug sense
    output logic             opticReturn,    // Five-wire echo
    output logic [7:0]       sensorWet,      // Wet pins
    output logic             groundOk,       // Ground proven
    output logic             vehicleIdOk     // Id module answer
);
    logic [15:0] warmCnt_ff;
    logic [7:0]  cold;

    always @(posedge clk) begin
        warmCnt_ff <= !plugged ? 16'h0000 : warmCnt_ff + {15'h0000, warmCnt_ff != 16'hffff};
    end

    // Sensors warm one after another, the last one at warmCyc
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            cold[i] = !optic && (32'(warmCnt_ff) * 8 < 32'(warmCyc) * (i + 1));
        end
    end

    // Rack inputs have pull-downs, so an open plug reads all low
    assign vehiclePresent = plugged;
    assign opticReturn    = plugged && optic && (wetCmd == 8'h00);
    assign sensorWet      = (plugged && !optic) ? (wetCmd | cold) : 8'h00;
    assign groundOk       = plugged && groundGood;
    assign vehicleIdOk    = plugged && idGood;
endmodule : opc_vehicle_model

/* testbench/tb_top.sv */
// Self-checking bench of the overfill permit controller with a vehicle model.
// Assumes shortened tick and time parameters; inputs move 1 ns after clk rises.
`timescale 1ns/1ps
module tb_top;
    localparam int TD = 2, OM = 10, WM = 80, CM = 600, SM = 8, FM = 4;
    logic clk = 0, sys_rst = 1, plugged = 0, optic = 0, groundGood = 1, idGood = 1, bypassKeyValid = 0;
    logic groundDetectJumper = 1, deadmanClosed = 1, deadmanNearEnd = 0, deadmanExpired = 0;
    logic [7:0]  wetCmd  = 8'h00;
    logic [15:0] warmCyc = 16'h0040;
    logic [31:0] seed    = 32'h6000;
    logic vehiclePresent, opticReturn, groundOk, vehicleIdOk, permit, redLamp, greenLamp, fiveWire;
    logic [7:0] sensorWet, compLamp;
    int fail_count = 0, cmp_count = 0, hi, lo;

    always #5 clk = ~clk;

    opc_vehicle_model i_veh (.clk(clk), .plugged(plugged), .optic(optic), .wetCmd(wetCmd), .warmCyc(warmCyc),
        .groundGood(groundGood), .idGood(idGood), .vehiclePresent(vehiclePresent), .opticReturn(opticReturn),
        .sensorWet(sensorWet), .groundOk(groundOk), .vehicleIdOk(vehicleIdOk));

    opc_permit_ctrl #(.TICK_DIV(TD), .SLOW_MS(SM), .FAST_MS(FM), .OPTIC_MS(OM), .WARM_MS(WM), .CLR_MS(CM)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .vehiclePresent(vehiclePresent), .opticReturn(opticReturn),
        .sensorWet(sensorWet), .groundOk(groundOk), .groundDetectJumper(groundDetectJumper),
        .vehicleIdOk(vehicleIdOk), .bypassKeyValid(bypassKeyValid), .deadmanClosed(deadmanClosed),
        .deadmanNearEnd(deadmanNearEnd), .deadmanExpired(deadmanExpired), .permit(permit),
        .redLamp(redLamp), .greenLamp(greenLamp), .compLamp(compLamp), .fiveWire(fiveWire));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Five-wire wetness is one lost echo, so it lands on lamp 0
    function automatic logic [7:0] exp_lamp(input logic opt, input logic [7:0] w);
        return opt ? {7'h00, |w} : w;
    endfunction : exp_lamp

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic chk_bit(input string n, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit

    task automatic chk_vec(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk_vec

    task automatic chk_num(input string n, input int e, input int g);
        cmp_count++;
        if (g != e) begin
            fail_count++;
            $display("BAD %s expected %0d seen %0d", n, e, g);
        end
    endtask : chk_num

    task automatic wait_permit(input logic e, input int n);
        for (int k = 0; k < n && permit !== e; k++) step(1);
        chk_bit("permit", e, permit);
    endtask : wait_permit

    // Counts one lit and one dark stretch of the green lamp, in clocks
    task automatic blink(output int h, output int l);
        h = 0;
        l = 0;
        for (int k = 0; k < 100 && greenLamp !== 1'b0; k++) step(1);
        for (int k = 0; k < 100 && greenLamp !== 1'b1; k++) step(1);
        for (; h < 100 && greenLamp === 1'b1; h++) step(1);
        for (; l < 100 && greenLamp !== 1'b1; l++) step(1);
    endtask : blink

    task automatic unplug();
        plugged = 0;
        wait_permit(1'b0, 4);
        for (int k = 0; k < 520 && compLamp !== 8'hff; k++) step(1);
        chk_vec("flash", 8'hff, compLamp);
        step((CM + 2) * TD + 4);
        chk_vec("blank", 8'h00, compLamp);
        chk_bit("red", 1'b1, redLamp);
    endtask : unplug

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end

    initial begin
        step(10);
        sys_rst = 0;
        chk_bit("permit", 1'b0, permit);
        chk_bit("red", 1'b1, redLamp);
        chk_vec("comp", 8'h00, compLamp);
        $display("test reset done");
        optic = 1;
        plugged = 1;
        wait_permit(1'b1, OM * TD + 10);
        chk_bit("fiveWire", 1'b1, fiveWire);
        chk_bit("green", 1'b1, greenLamp);
        for (int i = 0; i < 4; i++) begin
            wetCmd = 8'(rnd()) | (8'h01 << i);
            wait_permit(1'b0, 4);
            chk_vec("comp", exp_lamp(1'b1, wetCmd), compLamp);
            wetCmd = 8'h00;
            wait_permit(1'b1, 6);
        end
        deadmanClosed = 0;
        bypassKeyValid = 1;
        step(6);
        chk_bit("permit", 1'b0, permit);
        chk_vec("comp", 8'h00, compLamp);
        bypassKeyValid = 0;
        deadmanClosed = 1;
        wait_permit(1'b1, 6);
        deadmanNearEnd = 1;
        blink(hi, lo);
        chk_num("fastOn", FM / 2 * TD, hi);
        chk_num("fastOff", FM / 2 * TD, lo);
        deadmanExpired = 1;
        wait_permit(1'b0, 4);
        unplug();
        deadmanNearEnd = 0;
        deadmanExpired = 0;
        $display("test five-wire done");
        for (int f = 0; f < 3; f++) begin
            groundGood = (f == 1);
            idGood = (f != 1);
            groundDetectJumper = (f != 2);
            plugged = 1;
            step(OM * TD + 10);
            chk_bit("red", f != 2, redLamp);
            chk_bit("permit", f == 2, permit);
            bypassKeyValid = (f != 2);
            wait_permit(1'b1, 8);
            bypassKeyValid = 0;
            if (f < 2) begin
                blink(hi, lo);
                chk_num("slowOn", SM * 3 / 4 * TD, hi);
                chk_num("slowOff", SM / 4 * TD, lo);
            end
            unplug();
        end
        $display("test faults done");
        groundGood = 1;
        idGood = 1;
        groundDetectJumper = 1;
        optic = 0;
        warmCyc = 16'(OM * TD + 60 + rnd() % 40);
        plugged = 1;
        step(OM * TD + 8);
        chk_bit("permit", 1'b0, permit);
        chk_bit("lamp7", 1'b1, compLamp[7]);
        wait_permit(1'b1, int'(warmCyc));
        chk_bit("red", 1'b0, redLamp);
        chk_bit("fiveWire", 1'b0, fiveWire);
        for (int i = 0; i < 8; i++) begin
            wetCmd = 8'h01 << i;
            wait_permit(1'b0, 4);
            chk_vec("comp", exp_lamp(1'b0, wetCmd), compLamp);
            wetCmd = 8'h00;
            wait_permit(1'b1, 6);
        end
        unplug();
        $display("test thermistor done");
        // Corner: one sensor never dries, so warm-up times out into a sensor fault
        wetCmd = 8'h04;
        plugged = 1;
        step((OM + WM) * TD + 40);
        chk_bit("permit", 1'b0, permit);
        chk_vec("comp", exp_lamp(1'b0, 8'h04), compLamp);
        wetCmd = 8'h00;
        step(6);
        chk_bit("red", 1'b1, redLamp);
        wetCmd = 8'h04;
        bypassKeyValid = 1;
        step(6);
        chk_bit("permit", 1'b0, permit);
        bypassKeyValid = 0;
        wetCmd = 8'h00;
        wait_permit(1'b1, 6);
        chk_bit("green", 1'b1, greenLamp);
        unplug();
        $display("test warm-up timeout done");
        report_and_stop();
    end
endmodule : tb_top
